// ---- common/cse_map.svh ----
// register-free constant map for the switch-point evaluator
`ifndef CSE_MAP_SVH
`define CSE_MAP_SVH
`define CSE_CMD_FACTORY 8'h82
`define CSE_CMD_APP_RESET 8'h81
`define CSE_CMD_DIAG_RESET 8'he4
`define CSE_CMD_ALERT_CLR 8'he5
`define CSE_CMD_ALGO_RESET 8'hc0
`define CSE_CMD_TEACH_START 8'h4b
`define CSE_CMD_TEACH_STOP 8'h4c
`define CSE_CMD_TEACH_STORE 8'h4d
`define CSE_ACT_CLR_TRAVEL 8'h01
`define CSE_ACT_CLR_CYCLES 8'h02
`define CSE_MODE_SINGLE 8'h00
`define CSE_MODE_WINDOW 8'h01
`define CSE_MODE_TWO_POINT 8'h02
`define CSE_MODE_CYL 8'h03
`define CSE_MODE_MOVE 8'h82
`define CSE_MODE_GRIP 8'h83
`define CSE_HYST_DEF 16'h0046
`define CSE_HYST_MIN 16'h0001
`define CSE_HYST_MAX 16'h7fff
`define CSE_TOL_DEF 16'h0064
`define CSE_WIDTH_DEF 16'h00c8
`define CSE_WIDTH_MAX 16'h03e8
`define CSE_MIN_SEP 16'h0064
`define CSE_RANGE_LO 16'hf63c
`define CSE_RANGE_HI 16'h09c4
`define CSE_RELEARN_STROKES 2'h2
`define CSE_N_OUT 8
`endif

// ---- common/cse_pkg.sv ----
// types for the switch-point evaluator
`default_nettype none
package cse_pkg;
    typedef enum logic [1:0] {CSE_IDLE, CSE_TEACHING, CSE_TAUGHT} cse_teach_e;
    typedef logic signed [15:0] cse_pos_t;
endpackage : cse_pkg
`default_nettype wire

// ---- rtl/cse_evaluator.sv ----
// switch-point evaluation and system command handling
`timescale 1ns/1ns
`default_nettype none
`include "cse_map.svh"

// Functional notes
// RULE1 - command 130 restores defaults, clears learned data, keeps lifetime counters
// RULE2 - command 228 clears since-reset hours, power cycles, cycle count, travel
// RULE3 - command 229 clears all present alerts
// RULE4 - actuator reset value 2 clears only the cycle count
// RULE5 - actuator reset value 1 clears only total piston travel
// RULE6 - command 129 acts as factory restore but keeps identification
// RULE7 - command 192 drops learned data only, relearns within two strokes
// RULE8 - offset in 10 um steps is added to position before use
// RULE9 - offset change recomputes detection range and range descriptors
// RULE10 - teach starts on 75, stops on 76, stores on 77, in order
// RULE11 - dynamic teach keeps taught points at least 1 mm apart; code checks each stop only against the last stored stop
// RULE12 - dynamic teach sets mode 130 for two stops, 131 for three
// RULE13 - separate start and end points accepted only in window or two-point mode
// RULE14 - manual points carry no minimum spacing
// RULE15 - eight outputs, four manual modes, cylinder switch default
// RULE16 - single point: high above point, low below point minus hysteresis
// RULE17 - window: high between points, symmetric hysteresis at each
// RULE18 - two point: high after passing both, low below lower point
// RULE19 - cylinder switch: high within width around point, symmetric hysteresis
// RULE20 - per-output logic bit inverts output
// RULE21 - hysteresis defaults 0.7 mm, range 0.01 to 327.67 mm
// RULE22 - after dynamic teach switch only for stops within capture range
// RULE23 - capture tolerance defaults 1 mm, 10 um steps
// RULE24 - cylinder width defaults 2 mm, at most 10 mm
// RULE25 - unknown command codes are ignored
module cse_evaluator (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // position input, 10 um units
    input wire logic signed [15:0] raw_pos,
    input wire logic pos_valid,
    input wire logic stop_seen,
    input wire logic stroke_done,
    input wire logic alert_event,
    input wire logic hour_tick,
    input wire logic power_cycle,
    input wire logic [15:0] travel_inc,
    // system command
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic act_reset_valid,
    input wire logic [7:0] act_reset_code,
    // configuration writes
    input wire logic offset_we,
    input wire logic signed [15:0] offset_wdata,
    input wire logic cfg_we,
    input wire logic [2:0] cfg_sel,
    input wire logic [7:0] cfg_mode,
    input wire logic cfg_invert,
    input wire logic [15:0] cfg_hyst,
    input wire logic sp_we,
    input wire logic signed [15:0] sp_first,
    input wire logic signed [15:0] sp_second,
    input wire logic width_we,
    input wire logic [15:0] width_wdata,
    input wire logic tol_we,
    input wire logic [15:0] tol_wdata,
    // outputs
    output logic [7:0] switch_out,
    output logic signed [15:0] pos_out,
    output logic signed [15:0] range_lo,
    output logic signed [15:0] range_hi,
    output logic [7:0] alert_flags,
    output logic [15:0] hours_reset,
    output logic [15:0] power_reset,
    output logic [31:0] cycle_count,
    output logic [31:0] travel_total,
    output logic [1:0] teach_state,
    output logic [1:0] learn_strokes,
    output logic sp_reject
);
    cse_pkg::cse_teach_e tstate;
    logic signed [15:0] offset;
    logic [7:0] mode [0:7];
    logic [7:0] invert;
    logic [15:0] hyst [0:7];
    logic signed [15:0] spa [0:7];
    logic signed [15:0] spb [0:7];
    logic [15:0] width;
    logic [15:0] tol;
    logic signed [15:0] stops [0:2];
    logic [1:0] nstops;
    logic [7:0] state;

    wire signed [15:0] pos = 16'(raw_pos + offset);
    wire is_factory = cmd_valid && (cmd_code == `CSE_CMD_FACTORY || cmd_code == `CSE_CMD_APP_RESET);
    wire is_algo = cmd_valid && cmd_code == `CSE_CMD_ALGO_RESET;
    wire teach_start = cmd_valid && cmd_code == `CSE_CMD_TEACH_START;
    wire teach_stop = cmd_valid && cmd_code == `CSE_CMD_TEACH_STOP && tstate == cse_pkg::CSE_TEACHING;
    wire teach_store = cmd_valid && cmd_code == `CSE_CMD_TEACH_STORE && tstate == cse_pkg::CSE_TAUGHT;
    wire sp_ok = mode[cfg_sel] == `CSE_MODE_WINDOW || mode[cfg_sel] == `CSE_MODE_TWO_POINT;
    wire signed [15:0] last_stop = stops[nstops == 2'h0 ? 2'h0 : 2'(nstops - 2'h1)];
    wire sep_ok = nstops == 2'h0 || absdiff(pos, last_stop) >= `CSE_MIN_SEP;

    function automatic logic [15:0] absdiff(input logic signed [15:0] a, input logic signed [15:0] b);
        absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
    endfunction : absdiff

    function automatic logic [15:0] clamp_hyst(input logic [15:0] h);
        clamp_hyst = (h < `CSE_HYST_MIN) ? `CSE_HYST_MIN : (h > `CSE_HYST_MAX ? `CSE_HYST_MAX : h);
    endfunction : clamp_hyst

    // per-output next state, hysteresis evaluation
    logic [7:0] next_state;
    always_comb begin
        for (int i = 0; i < `CSE_N_OUT; i++) begin
            logic signed [16:0] p, a, b, h, w, t;
            p = 17'(pos);
            a = 17'(spa[i]);
            b = 17'(spb[i]);
            h = 17'({1'b0, hyst[i]});
            w = 17'({1'b0, width});
            t = 17'({1'b0, tol});
            next_state[i] = state[i];
            case (mode[i])
                // RULE16 single point
                `CSE_MODE_SINGLE: next_state[i] = state[i] ? (p >= a - h) : (p > a);
                // RULE17 window hysteresis
                `CSE_MODE_WINDOW: next_state[i] = state[i] ? (p >= a - h && p <= b + h) : (p > a + h && p < b - h);
                // RULE18 two point
                `CSE_MODE_TWO_POINT: next_state[i] = state[i] ? (p >= a) : (p > b);
                // RULE19 cylinder width
                `CSE_MODE_CYL: next_state[i] = state[i] ? (p >= a - w / 2 - h && p <= a + w / 2 + h)
                                                     : (p > a - w / 2 && p < a + w / 2);
                // RULE22 capture range
                `CSE_MODE_MOVE, `CSE_MODE_GRIP: next_state[i] = (p >= a - t) && (p <= a + t);
                default: next_state[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= 8'h00;
            switch_out <= 8'h00;
            pos_out <= 16'sh0000;
        end else if (pos_valid) begin
            state <= next_state;
            // RULE20 inversion
            switch_out <= next_state ^ invert;
            // RULE8 offset added
            pos_out <= pos;
        end
    end

    // RULE9 range recompute
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            range_lo <= `CSE_RANGE_LO;
            range_hi <= `CSE_RANGE_HI;
        end else begin
            range_lo <= 16'(`CSE_RANGE_LO + offset);
            range_hi <= 16'(`CSE_RANGE_HI + offset);
        end
    end

    // configuration, teach and command handling
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            offset <= 16'sh0000;
            invert <= 8'h00;
            width <= `CSE_WIDTH_DEF;
            tol <= `CSE_TOL_DEF;
            tstate <= cse_pkg::CSE_IDLE;
            nstops <= 2'h0;
            learn_strokes <= 2'h0;
            sp_reject <= 1'b0;
            for (int i = 0; i < `CSE_N_OUT; i++) begin
                mode[i] <= `CSE_MODE_CYL;
                hyst[i] <= `CSE_HYST_DEF;
                spa[i] <= 16'sh0000;
                spb[i] <= 16'sh0000;
            end
            for (int j = 0; j < 3; j++) begin
                stops[j] <= 16'sh0000;
            end
        end else if (is_factory) begin
            // RULE1 factory restore
            // RULE6 app reset same path
            offset <= 16'sh0000;
            invert <= 8'h00;
            width <= `CSE_WIDTH_DEF;
            tol <= `CSE_TOL_DEF;
            tstate <= cse_pkg::CSE_IDLE;
            nstops <= 2'h0;
            learn_strokes <= 2'h0;
            sp_reject <= 1'b0;
            for (int i = 0; i < `CSE_N_OUT; i++) begin
                mode[i] <= `CSE_MODE_CYL;
                hyst[i] <= `CSE_HYST_DEF;
                spa[i] <= 16'sh0000;
                spb[i] <= 16'sh0000;
            end
        end else begin
            // RULE7 relearn count
            if (is_algo) begin
                learn_strokes <= 2'h0;
            end else if (stroke_done && learn_strokes != `CSE_RELEARN_STROKES) begin
                learn_strokes <= 2'(learn_strokes + 2'h1);
            end
            if (offset_we) begin
                offset <= offset_wdata;
            end
            // RULE23 tolerance set
            if (tol_we) begin
                tol <= tol_wdata;
            end
            // RULE24 width limit
            if (width_we) begin
                width <= (width_wdata > `CSE_WIDTH_MAX) ? `CSE_WIDTH_MAX : width_wdata;
            end
            // RULE15 manual modes only
            if (cfg_we) begin
                invert[cfg_sel] <= cfg_invert;
                // RULE21 hysteresis range
                hyst[cfg_sel] <= clamp_hyst(cfg_hyst);
                if (cfg_mode <= `CSE_MODE_CYL && mode[cfg_sel] <= `CSE_MODE_CYL) begin
                    mode[cfg_sel] <= cfg_mode;
                end
            end
            // RULE13 point write gate
            // RULE14 no manual spacing
            sp_reject <= sp_we && !sp_ok;
            if (sp_we && sp_ok) begin
                spa[cfg_sel] <= sp_first;
                spb[cfg_sel] <= sp_second;
            end
            // RULE10 teach sequence
            if (teach_start) begin
                tstate <= cse_pkg::CSE_TEACHING;
                nstops <= 2'h0;
            end else if (teach_stop) begin
                tstate <= cse_pkg::CSE_TAUGHT;
            end else if (teach_store) begin
                tstate <= cse_pkg::CSE_IDLE;
                // RULE12 automatic mode
                if (nstops >= 2'h2) begin
                    for (int i = 0; i < 3; i++) begin
                        if (i < nstops) begin
                            spa[i] <= stops[i];
                            hyst[i] <= `CSE_HYST_DEF;
                            mode[i] <= (nstops == 2'h3) ? `CSE_MODE_GRIP : `CSE_MODE_MOVE;
                        end
                    end
                end
            // RULE11 teach spacing
            end else if (tstate == cse_pkg::CSE_TEACHING && stop_seen && sep_ok && nstops != 2'h3) begin
                stops[nstops] <= pos;
                nstops <= 2'(nstops + 2'h1);
            end
        end
    end

    // counters and alerts; RULE25 others ignored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_flags <= 8'h00;
            hours_reset <= 16'h0000;
            power_reset <= 16'h0000;
            cycle_count <= 32'h0000_0000;
            travel_total <= 32'h0000_0000;
        end else begin
            // RULE3 alert clear, set wins
            alert_flags <= (cmd_valid && cmd_code == `CSE_CMD_ALERT_CLR) ? {7'h00, alert_event}
                                                                         : alert_flags | {7'h00, alert_event};
            if (cmd_valid && cmd_code == `CSE_CMD_DIAG_RESET) begin
                // RULE2 diagnostic clear
                hours_reset <= 16'h0000;
                power_reset <= 16'h0000;
                cycle_count <= 32'h0000_0000;
                travel_total <= 32'h0000_0000;
            end else begin
                hours_reset <= 16'(hours_reset + {15'h0000, hour_tick});
                power_reset <= 16'(power_reset + {15'h0000, power_cycle});
                // RULE4 cycle clear
                cycle_count <= (act_reset_valid && act_reset_code == `CSE_ACT_CLR_CYCLES) ? 32'h0000_0000
                             : 32'(cycle_count + {31'h0, stroke_done});
                // RULE5 travel clear
                travel_total <= (act_reset_valid && act_reset_code == `CSE_ACT_CLR_TRAVEL) ? 32'h0000_0000
                              : 32'(travel_total + {16'h0000, travel_inc});
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            teach_state <= 2'h0;
        end else begin
            teach_state <= 2'(tstate);
        end
    end

    // RULE24 width bound
    a_width_bound: assert property (@(posedge core_clk) disable iff (!rst_n) width <= `CSE_WIDTH_MAX) // RULE24
        else $error("width above maximum");
    // RULE21 hysteresis bound
    a_hyst_range: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE21
        cfg_we |=> hyst[$past(cfg_sel)] >= `CSE_HYST_MIN) else $error("hysteresis below minimum");
    // RULE2 diag clear
    a_diag_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE2
        cmd_valid && cmd_code == `CSE_CMD_DIAG_RESET |=> cycle_count == 0 && hours_reset == 0)
        else $error("diagnostic counters not cleared");
    // RULE1 keeps counters
    a_factory_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE1
        is_factory && !act_reset_valid && !stroke_done |=> cycle_count == $past(cycle_count))
        else $error("factory restore touched cycle count");
    // RULE4 cycle only
    a_cycle_only: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
        act_reset_valid && act_reset_code == `CSE_ACT_CLR_CYCLES && !cmd_valid && travel_inc == 0
        |=> cycle_count == 0 && travel_total == $past(travel_total)) else $error("cycle reset wrong");
    // RULE5 travel only
    a_travel_only: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
        act_reset_valid && act_reset_code == `CSE_ACT_CLR_TRAVEL && !cmd_valid && !stroke_done
        |=> travel_total == 0 && cycle_count == $past(cycle_count)) else $error("travel reset wrong");
    // RULE13 point gate
    a_sp_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
        sp_we && !sp_ok && !is_factory && !teach_store |=> sp_reject && spa[$past(cfg_sel)] == $past(spa[cfg_sel]))
        else $error("point written in wrong mode");
    // RULE20 inversion
    a_invert_out: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE20
        pos_valid |=> switch_out == (state ^ invert) || $past(cfg_we) || $past(is_factory))
        else $error("output polarity wrong");
    // RULE12 two stops give move mode
    sequence s_store_two;
        teach_store && nstops == 2'h2;
    endsequence
    a_auto_mode: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
        s_store_two |=> mode[0] == `CSE_MODE_MOVE && mode[1] == `CSE_MODE_MOVE)
        else $error("automatic mode not set");
endmodule : cse_evaluator
`default_nettype wire

// ---- verif/cse_link_master.sv ----
// link master model issuing system and actuator commands
`timescale 1ns/1ns
`default_nettype none
module cse_link_master (
    // clock
    input wire logic core_clk,
    // command strobes
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic act_reset_valid,
    output logic [7:0] act_reset_code
);
    int gap = 0;
    initial begin
        cmd_valid = 1'h0;
        cmd_code = 8'h5a;
        act_reset_valid = 1'h0;
        act_reset_code = 8'ha5;
    end
    // idle gap, one-cycle strobe, then scramble the released code lines
    task automatic send(input logic act, input logic [7:0] code);
        repeat (gap) @(negedge core_clk);
        if (act) begin
            act_reset_code = code;
            act_reset_valid = 1'h1;
        end else begin
            cmd_code = code;
            cmd_valid = 1'h1;
        end
        @(negedge core_clk);
        cmd_valid = 1'h0;
        act_reset_valid = 1'h0;
        cmd_code = ~cmd_code;
        act_reset_code = ~act_reset_code;
        repeat (3) @(negedge core_clk);
    endtask : send
endmodule : cse_link_master
`default_nettype wire

// ---- verif/cse_evaluator_tb.sv ----
// self-checking bench for the switch-point evaluator
`timescale 1ns/1ns
`default_nettype none
`include "cse_map.svh"
module cse_evaluator_tb;
    logic core_clk = '0, rst_n = '0;
    logic signed [15:0] raw_pos = '0, offset_wdata = '0, sp_first = '0, sp_second = '0;
    logic pos_valid = '0, stop_seen = '0, stroke_done = '0, alert_event = '0, hour_tick = '0, power_cycle = '0;
    logic offset_we = '0, cfg_we = '0, cfg_invert = '0, sp_we = '0, width_we = '0, tol_we = '0;
    logic [15:0] travel_inc = '0, cfg_hyst = '0, width_wdata = '0, tol_wdata = '0;
    logic [2:0] cfg_sel = '0;
    logic [7:0] cfg_mode = '0;
    logic cmd_valid, act_reset_valid, sp_reject;
    logic [7:0] cmd_code, act_reset_code, switch_out, alert_flags;
    logic signed [15:0] pos_out, range_lo, range_hi;
    logic [15:0] hours_reset, power_reset;
    logic [31:0] cycle_count, travel_total;
    logic [1:0] teach_state, learn_strokes;
    int errors = 0, tests_run = 0;
    int unsigned seed = 32'hcf342d15;
    int md[8], pa[8], pb[8], hy[8], iv[8], st[8] = '{default: 0};
    int off, wid, tol, a, b;

    always #20 core_clk = ~core_clk;

    cse_evaluator u_cse_evaluator (.core_clk(core_clk), .rst_n(rst_n), .raw_pos(raw_pos), .pos_valid(pos_valid),
        .stop_seen(stop_seen), .stroke_done(stroke_done), .alert_event(alert_event), .hour_tick(hour_tick),
        .power_cycle(power_cycle), .travel_inc(travel_inc), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .act_reset_valid(act_reset_valid), .act_reset_code(act_reset_code), .offset_we(offset_we),
        .offset_wdata(offset_wdata), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_mode(cfg_mode),
        .cfg_invert(cfg_invert), .cfg_hyst(cfg_hyst), .sp_we(sp_we), .sp_first(sp_first), .sp_second(sp_second),
        .width_we(width_we), .width_wdata(width_wdata), .tol_we(tol_we), .tol_wdata(tol_wdata),
        .switch_out(switch_out), .pos_out(pos_out), .range_lo(range_lo), .range_hi(range_hi),
        .alert_flags(alert_flags), .hours_reset(hours_reset), .power_reset(power_reset),
        .cycle_count(cycle_count), .travel_total(travel_total), .teach_state(teach_state),
        .learn_strokes(learn_strokes), .sp_reject(sp_reject));
    cse_link_master u_cse_link_master (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .act_reset_valid(act_reset_valid), .act_reset_code(act_reset_code));

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    function automatic void mdl_reset();
        md = '{default: 3};
        pa = '{default: 0};
        pb = '{default: 0};
        hy = '{default: 70};
        iv = '{default: 0};
        off = 0;
        wid = 200;
        tol = 100;
    endfunction : mdl_reset
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge core_clk);
        s = 1'h0;
        repeat (3) @(negedge core_clk);
    endtask : pulse
    task automatic cmd(input logic act, input logic [7:0] code);
        u_cse_link_master.gap = int'(rnd() % 4);
        u_cse_link_master.send(act, code);
    endtask : cmd
    task automatic trav();
        travel_inc = 16'h0005;
        repeat (4) @(negedge core_clk);
        travel_inc = 16'h0000;
        pulse(stroke_done);
    endtask : trav
    task automatic pos(input int r);
        logic [7:0] e;
        int q, h, w;
        raw_pos = 16'(r);
        pulse(pos_valid);
        q = r + off;
        w = wid / 2;
        for (int i = 0; i < 8; i++) begin
            h = hy[i];
            case (md[i])
                0: if (q > pa[i]) st[i] = 1;
                   else if (q < pa[i] - h) st[i] = 0;
                1: if (q > pa[i] + h && q < pb[i] - h) st[i] = 1;
                   else if (q < pa[i] - h || q > pb[i] + h) st[i] = 0;
                2: if (q > pb[i]) st[i] = 1;
                   else if (q < pa[i]) st[i] = 0;
                3: if (q > pa[i] - w && q < pa[i] + w) st[i] = 1;
                   else if (q < pa[i] - w - h || q > pa[i] + w + h) st[i] = 0;
                default: st[i] = int'(q >= pa[i] - tol && q <= pa[i] + tol);
            endcase
            e[i] = st[i][0] ^ iv[i][0];
        end
        chk(pos_out, q);
        chk(switch_out, e);
    endtask : pos
    task automatic rpos(input int n);
        repeat (n) pos(int'(rnd() % 1001) * 2 - 999);
    endtask : rpos
    task automatic cfg(input int i, input int m, input int v, input int h);
        cfg_sel = 3'(i);
        cfg_mode = 8'(m);
        cfg_invert = v[0];
        cfg_hyst = 16'(h);
        pulse(cfg_we);
        if (md[i] < 4) md[i] = m;
        iv[i] = v;
        hy[i] = h > 32767 ? 32767 : h;
        pos(1999);
    endtask : cfg
    task automatic sp(input int i, input int f, input int s);
        cfg_sel = 3'(i);
        sp_first = 16'(f);
        sp_second = 16'(s);
        sp_we = 1'h1;
        @(negedge core_clk);
        sp_we = 1'h0;
        chk(sp_reject, md[i] != 1 && md[i] != 2);
        @(negedge core_clk);
        chk(sp_reject, 0);
        repeat (2) @(negedge core_clk);
        if (md[i] == 1 || md[i] == 2) begin
            pa[i] = f;
            pb[i] = s;
        end
    endtask : sp
    task automatic teach(input int k);
        cmd(0, `CSE_CMD_TEACH_START);
        chk(teach_state, cse_pkg::CSE_TEACHING);
        for (int j = 0; j < k; j++) begin
            raw_pos = 16'(400 * j - 400);
            pulse(stop_seen);
            raw_pos = 16'(400 * j - 350);
            pulse(stop_seen);
        end
        cmd(0, `CSE_CMD_TEACH_STOP);
        chk(teach_state, cse_pkg::CSE_TAUGHT);
        cmd(0, `CSE_CMD_TEACH_STORE);
        chk(teach_state, cse_pkg::CSE_IDLE);
        for (int j = 0; j < k; j++) begin
            md[j] = k == 2 ? 130 : 131;
            pa[j] = 400 * j - 400;
        end
        pos(1999);
        rpos(20);
    endtask : teach

    initial begin
        #800000;
        errors++;
        final_report();
    end
    initial begin
        mdl_reset();
        repeat (16) @(negedge core_clk);
        rst_n = 1'h1;
        @(negedge core_clk);
        chk(range_lo, -2500);
        chk(switch_out, 8'h00);
        repeat (3) pulse(hour_tick);
        repeat (2) pulse(power_cycle);
        repeat (2) pulse(stroke_done);
        trav();
        chk(travel_total, 20);
        chk(learn_strokes, 2);
        cmd(1, `CSE_ACT_CLR_CYCLES);
        chk(cycle_count, 0);
        chk(travel_total, 20);
        pulse(stroke_done);
        cmd(1, `CSE_ACT_CLR_TRAVEL);
        chk(travel_total, 0);
        chk(cycle_count != 0, 1);
        repeat (4) cmd(0, 8'h10 + 8'(rnd() % 32));
        chk({hours_reset, power_reset}, 32'h00030002);
        cmd(0, `CSE_CMD_ALGO_RESET);
        chk(learn_strokes, 0);
        chk(hours_reset, 3);
        repeat (2) pulse(stroke_done);
        chk(learn_strokes, 2);
        trav();
        cmd(0, `CSE_CMD_DIAG_RESET);
        chk({hours_reset, power_reset}, 0);
        chk(cycle_count, 0);
        chk(travel_total, 0);
        pulse(alert_event);
        chk(alert_flags, 8'h01);
        cmd(0, `CSE_CMD_ALERT_CLR);
        chk(alert_flags, 8'h00);
        pos(51);
        rpos(20);
        off = int'(rnd() % 501) * 2 - 500;
        offset_wdata = 16'(off);
        pulse(offset_we);
        chk(range_lo, off - 2500);
        chk(range_hi, off + 2500);
        rpos(20);
        for (int i = 0; i < 8; i++) begin
            a = -int'(rnd() % 300) * 2;
            b = a + 200 + int'(rnd() % 200) * 2;
            cfg(i, 1, 0, 70);
            sp(i, a, b);
            cfg(i, int'(rnd() % 4), int'(rnd() % 2), i == 7 ? 40000 : int'(rnd() % 150) * 2 + 2);
            sp(i, a - 2, b + 2);
        end
        rpos(40);
        width_wdata = 16'h0bb8;
        pulse(width_we);
        wid = 1000;
        pos(1999);
        rpos(20);
        for (int j = 0; j < 2; j++) begin
            trav();
            cmd(0, j == 0 ? `CSE_CMD_FACTORY : `CSE_CMD_APP_RESET);
            mdl_reset();
            chk(travel_total, 20 * (j + 1));
            chk(cycle_count, j + 1);
            chk(learn_strokes, 0);
            chk(range_hi, 2500);
            pos(1999);
            rpos(10);
        end
        teach(2);
        tol = int'(rnd() % 100) * 2 + 40;
        tol_wdata = 16'(tol);
        pulse(tol_we);
        teach(3);
        // manual mode refused after dynamic teach, invert still taken
        cfg(0, 1, 1, 70);
        rpos(10);
        final_report();
    end
endmodule : cse_evaluator_tb
`default_nettype wire
